/* dv/pfx_far.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pfx_far (
    input  wire logic       mclk,
    input  wire logic [5:0] level,
    output logic      [5:0] pin
);
    // connector sources move just after an edge, never on it
    always_ff @(posedge mclk) begin
        pin <= level;
    end
endmodule : pfx_far

/* dv/pfx_top_test.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pfx_top_test;
    logic        mclk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, hold_complete_event, frequency_output;
    logic        star_trigger_in, star_trigger_filtered, fq_d, old5;
    logic [8:0]  sd;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, sync_bus_line_in, sync_bus_line_out;
    logic [7:0]  sync_bus_line_filtered;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, pin_out, powerup_level, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, counter_source, counter_gate;
    logic [1:0]  counter_internal_output;
    logic [5:0]  level, pin, static_input_port;
    logic [23:0] dest_out;
    int          miscompares, total_checks, hit[4];
    pfx_far far (.mclk, .level, .pin);
    // slow filter count shortened so the run stays brief
    pfx_top #(.SLOW_N(17'h14)) dut (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .programmable_function_pin_in(pin), .programmable_function_pin_out(pin_out),
        .powerup_level, .hold_complete_event, .counter_source, .counter_gate,
        .counter_internal_output, .frequency_output, .star_trigger_in,
        .sync_bus_line_in, .dest_out, .static_input_port, .sync_bus_line_out,
        .sync_bus_line_filtered, .star_trigger_filtered);
    ////////////////////////////////////////////////////////////////////////////
    // samples a setting needs; index i is the setting code
    function automatic int nsamp(input int i);
        return (i == 0) ? 0 : (i == 1) ? 5 : (i == 2) ? 257 : 20;
    endfunction : nsamp
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp
    // each half is dropped the edge it is taken; bready held until bvalid
    // flags are read mid-cycle, where they equal what the next rising edge sees
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_go, w_go, b_go;
        {aw_go, w_go, b_go} = 3'b111;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (b_go) begin
            @(negedge mclk);
            if (s_axi_awready) aw_go = 1'b0;
            if (s_axi_wready) w_go = 1'b0;
            if (s_axi_bvalid) b_go = 1'b0;
            if (s_axi_bvalid) cmp(s_axi_bresp, 2'h0);
            @(posedge mclk);
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw_go, w_go, b_go};
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ar_go, r_go;
        {ar_go, r_go} = 2'b11;
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        while (r_go) begin
            @(negedge mclk);
            if (s_axi_arready) ar_go = 1'b0;
            if (s_axi_rvalid) r_go = 1'b0;
            if (s_axi_rvalid) cmp(s_axi_rdata, e);
            if (s_axi_rvalid) cmp(s_axi_rresp, r);
            @(posedge mclk);
            {s_axi_arvalid, s_axi_rready} <= {ar_go, r_go};
        end
    endtask : rd
    task results;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // a hang costs a mismatch rather than an endless run
    initial begin
        #400000;
        miscompares++;
        results();
    end
    // internal timing sources toggle at random every cycle
    always @(posedge mclk) begin
        {hold_complete_event, counter_source, counter_gate, counter_internal_output,
         frequency_output, star_trigger_in, sync_bus_line_in} <= 17'($urandom);
        fq_d <= frequency_output;
        sd <= {star_trigger_in, sync_bus_line_in};
    end
    initial begin
        void'($urandom(36));
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, level} = '0;
        s_axi_wstrb = 4'hf;
        powerup_level = 4'($urandom);
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        cmp(pin_out, powerup_level);
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h00, 32'h0f);
        wr(8'h04, 32'he4);
        // a three cycle pulse is shorter than five samples
        level <= 6'h02;
        repeat (3) @(posedge mclk);
        level <= 6'h00;
        repeat (12) @(posedge mclk);
        cmp(static_input_port, 6'h00);
        // pins 0..3 carry off, fast, mid and slow settings
        level <= 6'h0f;
        for (int c = 1; c < 400; c++) begin
            @(negedge mclk);
            for (int i = 0; i < 4; i++)
                if (static_input_port[i] === 1'b1 && hit[i] == 0) hit[i] = c;
        end
        for (int i = 0; i < 4; i++)
            cmp(hit[i] >= nsamp(i) && hit[i] <= nsamp(i) * 5 / 4 + 6, 1);
        d = 4'($urandom);
        wr(8'h0c, {28'h0, d});
        repeat (3) @(posedge mclk);
        cmp(pin_out, d);
        wr(8'h14, 32'h7);
        wr(8'h10, 32'h1);
        repeat (20) begin
            @(negedge mclk);
            cmp(pin_out, {d[3:1], fq_d});
            cmp({star_trigger_filtered, sync_bus_line_filtered}, sd);
        end
        wr(8'h40, 32'h2c);
        wr(8'h44, 32'h35);
        wr(8'h9c, 32'h25);
        wr(8'h18, 32'h0d);
        // destination 1 is edge mode: a one-cycle pulse on a rising pin 5
        repeat (8) begin
            old5 = level[5];
            level <= 6'($urandom);
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            cmp({dest_out[23], dest_out[1], dest_out[0], static_input_port[5:4]},
                {level[5], level[5] & ~old5, ~level[4], 2'b00});
            cmp(sync_bus_line_out[0], level[5]);
        end
        results();
    end
endmodule : pfx_top_test

/* src/pfx_debounce.sv */
`timescale 1ns/1ps
`include "pfx_defines.svh"

module pfx_debounce
    import pfx_pkg::*;
#(
    parameter logic [16:0] SLOW_N = `PFX_SLOW_N
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       tick,
    input  wire logic       raw,
    input  wire logic [1:0] setting,
    output logic            filtered
);

    pfx_deb_s    q;
    pfx_deb_s    next_q;
    logic [16:0] n_sel;

    ////////////////////////////////////////////////////////////////////////
    // sample count needed for the chosen setting
    always_comb begin
        unique case (setting)
            `PFX_FILT_OFF:  n_sel = '0;
            `PFX_FILT_FAST: n_sel = `PFX_FAST_N;
            `PFX_FILT_MID:  n_sel = `PFX_MID_N;
            `PFX_FILT_SLOW: n_sel = SLOW_N;
        endcase
    end

    // a new level passes only after n matching samples in a row
    always_comb begin
        next_q = q;
        if (setting == `PFX_FILT_OFF) begin
            next_q.level = raw;
            next_q.cnt   = '0;
        end else if (raw == q.level) begin
            next_q.cnt = '0;
        end else if (tick) begin
            if (q.cnt + 17'h1 >= n_sel) begin
                next_q.level = raw;
                next_q.cnt   = '0;
            end else begin
                next_q.cnt = q.cnt + 17'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign filtered = q.level;

    ////////////////////////////////////////////////////////////////////////
    chk_filter_settle: assert property (@(posedge mclk) disable iff (!reset_n)
        ($changed(filtered) && $past(setting) != `PFX_FILT_OFF)
        |-> ($past(q.cnt) + 17'h1 >= $past(n_sel)) && $past(tick))
        else $error("filtered level changed before n samples");
    chk_filter_glitch: assert property (@(posedge mclk) disable iff (!reset_n)
        (setting != `PFX_FILT_OFF && raw == filtered) |=> q.cnt == 17'h0)
        else $error("sample count not restarted on matching sample");
    chk_filter_bypass: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && setting == `PFX_FILT_OFF) |=> filtered == $past(raw))
        else $error("disabled filter did not pass input");

endmodule : pfx_debounce

/* src/pfx_defines.svh */
`ifndef PFX_DEFINES_SVH
`define PFX_DEFINES_SVH

// line counts
`define PFX_N_IN          6
`define PFX_N_OUT         4
`define PFX_N_SYNC        8
`define PFX_N_FILT        15
`define PFX_N_DEST        24
`define PFX_N_SRC         17

// register word offsets (byte addresses)
`define PFX_OFF_IN_MODE    8'h00
`define PFX_OFF_FILT_SEL   8'h04
`define PFX_OFF_STATIC_IN  8'h08
`define PFX_OFF_STATIC_OUT 8'h0c
`define PFX_OFF_OUT_MODE   8'h10
`define PFX_OFF_OUT_SEL    8'h14
`define PFX_OFF_SYNC_ROUTE 8'h18
`define PFX_OFF_STATUS     8'h1c
`define PFX_OFF_DEST_BASE  8'h40
`define PFX_OFF_DEST_LAST  8'h9c

// axi responses
`define PFX_RESP_OKAY     2'h0
`define PFX_RESP_SLVERR   2'h2

// filter setting codes, two bits per filtered input
`define PFX_FILT_OFF      2'h0
`define PFX_FILT_FAST     2'h1
`define PFX_FILT_MID      2'h2
`define PFX_FILT_SLOW     2'h3

// samples needed to pass a new level
`define PFX_FAST_N        17'h00005
`define PFX_MID_N         17'h00101
`define PFX_SLOW_N        17'h18da8

// filter sample rate derived from the system clock
`define PFX_MCLK_MHZ      50
`define PFX_FCLK_MHZ      40
`define PFX_TICK_PERIOD   3'(`PFX_MCLK_MHZ / (`PFX_MCLK_MHZ - `PFX_FCLK_MHZ))

// destination config fields
`define PFX_DCFG_SEL_LSB  0
`define PFX_DCFG_INV      3
`define PFX_DCFG_EDGE     4
`define PFX_DCFG_EN       5

// sync route fields, four bits per sync bus line
`define PFX_SR_EN         3

`endif

/* src/pfx_dest.sv */
`timescale 1ns/1ps
`include "pfx_defines.svh"

module pfx_dest
    import pfx_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [5:0] lines,
    input  wire logic [5:0] cfg,
    output logic            dest
);

    pfx_dest_s q;
    pfx_dest_s next_q;
    logic      level;

    ////////////////////////////////////////////////////////////////////////
    // pick a line, apply polarity, then level or rising-edge pulse
    always_comb begin
        level = 1'b0;
        if (cfg[`PFX_DCFG_SEL_LSB +: 3] < 3'(`PFX_N_IN)) begin
            level = lines[cfg[`PFX_DCFG_SEL_LSB +: 3]];
        end
        level       = level ^ cfg[`PFX_DCFG_INV];
        next_q.prev = level;
        next_q.out  = cfg[`PFX_DCFG_EN] &
                      (cfg[`PFX_DCFG_EDGE] ? (level & ~q.prev) : level);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign dest = q.out;

    ////////////////////////////////////////////////////////////////////////
    chk_dest_edge: assert property (@(posedge mclk) disable iff (!reset_n)
        (dest && $past(cfg[`PFX_DCFG_EDGE])) |=> !dest || !$past(cfg[`PFX_DCFG_EDGE]))
        else $error("edge mode pulse lasted more than one cycle");

endmodule : pfx_dest

/* src/pfx_pkg.sv */
package pfx_pkg;
`include "pfx_defines.svh"

    typedef struct packed {
        logic        level;
        logic [16:0] cnt;
    } pfx_deb_s;

    typedef struct packed {
        logic prev;
        logic out;
    } pfx_dest_s;

    typedef struct packed {
        logic                   aw_held;
        logic [7:0]             aw_addr;
        logic                   w_held;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
        logic [5:0]             in_mode;
        logic [29:0]            filt_sel;
        logic [3:0]             out_mode;
        logic [19:0]            out_sel;
        logic [3:0]             out_data;
        logic [31:0]            sync_route;
        logic [23:0][5:0]       dest_cfg;
        logic [2:0]             tick_cnt;
        logic                   strap_done;
        logic [3:0]             pin_out;
        logic [7:0]             sync_out;
        logic [5:0]             static_in;
    } pfx_top_s;

endpackage : pfx_pkg

/* src/pfx_top.sv */
// How it works
// - ten function lines: six input-only pins and four output-only pins.
// - each input pin is a timing input or a static input port bit.
// - each output pin exports a timing signal or a static output port bit.
// - any input pin routes to any analog or counter destination.
// - each destination chooses its polarity and edge or level sensing.
// - any output pin selects hold complete, counter, frequency, star or sync lines.
// - pins, sync bus and star inputs each have a debounce filter at 40 MHz.
// - a new level passes only after n consecutive matching samples.
// - settings give n of 5, 257 or 101800 samples, or bypass.
// - every filtered input holds its own filter setting.
// - all filters come out of reset disabled.
// - filter jitter stays within 25 ns for the short settings.
// - direct pin to sync bus and sync bus to pin paths are unfiltered.
// - output pins start low, or at a per-line power-up level.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pfx_defines.svh"

module pfx_top
    import pfx_pkg::*;
#(
    parameter logic [16:0] SLOW_N = `PFX_SLOW_N
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // axi4-lite slave
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // connector side
    input  wire logic [5:0]   programmable_function_pin_in,
    output logic [3:0]        programmable_function_pin_out,
    input  wire logic [3:0]   powerup_level,
    // internal timing sources
    input  wire logic         hold_complete_event,
    input  wire logic [1:0]   counter_source,
    input  wire logic [1:0]   counter_gate,
    input  wire logic [1:0]   counter_internal_output,
    input  wire logic         frequency_output,
    input  wire logic         star_trigger_in,
    input  wire logic [7:0]   sync_bus_line_in,
    // routed results
    output logic [23:0]       dest_out,
    output logic [5:0]        static_input_port,
    output logic [7:0]        sync_bus_line_out,
    output logic [7:0]        sync_bus_line_filtered,
    output logic              star_trigger_filtered
);

    pfx_top_s         q;
    pfx_top_s         next_q;
    logic [14:0]      filt_raw;
    logic [14:0]      filt_lvl;
    logic [5:0]       timing_lines;
    logic [16:0]      src_vec;
    logic             filt_tick;
    logic             wr_fire;
    logic             rd_fire;
    logic [5:0]       wr_idx;
    logic [5:0]       rd_idx;
    logic             wr_hit;
    logic             rd_hit;
    logic [31:0]      rd_word;

    ////////////////////////////////////////////////////////////////////////
    // merge a written word into a register under byte strobes
    function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_word

    ////////////////////////////////////////////////////////////////////////
    // 40 mhz sample tick from the 50 mhz clock: four ticks in every five
    // cycles, so sampling spacing varies by one cycle, 20 ns of jitter
    assign filt_tick = (q.tick_cnt != `PFX_TICK_PERIOD - 3'h1);

    // filtered inputs: six pins, eight sync bus lines, one star trigger
    assign filt_raw = {star_trigger_in, sync_bus_line_in, programmable_function_pin_in};

    for (genvar i = 0; i < `PFX_N_FILT; i++) begin : g_filt
        pfx_debounce #(
            .SLOW_N   (SLOW_N)
        ) u_deb (
            .mclk     (mclk),
            .reset_n  (reset_n),
            .tick     (filt_tick),
            .raw      (filt_raw[i]),
            .setting  (q.filt_sel[i*2 +: 2]),
            .filtered (filt_lvl[i])
        );
    end

    // static-mode pins are withheld from the timing routes
    assign timing_lines = filt_lvl[5:0] & ~q.in_mode;

    // every destination can take any of the six pins
    for (genvar d = 0; d < `PFX_N_DEST; d++) begin : g_dest
        pfx_dest u_dest (
            .mclk    (mclk),
            .reset_n (reset_n),
            .lines   (timing_lines),
            .cfg     (q.dest_cfg[d]),
            .dest    (dest_out[d])
        );
    end

    // export sources; sync lines are raw since pin paths bypass the filter
    assign src_vec = {sync_bus_line_in, star_trigger_in, frequency_output,
                      counter_internal_output[1], counter_gate[1], counter_source[1],
                      counter_internal_output[0], counter_gate[0], counter_source[0],
                      hold_complete_event};

    ////////////////////////////////////////////////////////////////////////
    // bus handshake terms
    assign s_axi_awready = !q.aw_held && !q.bvalid;
    assign s_axi_wready  = !q.w_held && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign wr_fire       = q.aw_held && q.w_held && !q.bvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign wr_idx        = q.aw_addr[7:2];
    assign rd_idx        = s_axi_araddr[7:2];

    // write decode: only writable words answer okay
    always_comb begin
        unique case (q.aw_addr & 8'hfc)
            `PFX_OFF_IN_MODE, `PFX_OFF_FILT_SEL, `PFX_OFF_STATIC_OUT,
            `PFX_OFF_OUT_MODE, `PFX_OFF_OUT_SEL, `PFX_OFF_SYNC_ROUTE: wr_hit = 1'b1;
            default: wr_hit = (q.aw_addr >= `PFX_OFF_DEST_BASE) &&
                              (q.aw_addr <= `PFX_OFF_DEST_LAST + 8'h3);
        endcase
    end

    // read mux; reserved bits read zero
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr & 8'hfc)
            `PFX_OFF_IN_MODE:    rd_word[5:0]  = q.in_mode;
            `PFX_OFF_FILT_SEL:   rd_word[29:0] = q.filt_sel;
            `PFX_OFF_STATIC_IN:  rd_word[5:0]  = q.static_in;
            `PFX_OFF_STATIC_OUT: rd_word[3:0]  = q.out_data;
            `PFX_OFF_OUT_MODE:   rd_word[3:0]  = q.out_mode;
            `PFX_OFF_OUT_SEL:    rd_word[19:0] = q.out_sel;
            `PFX_OFF_SYNC_ROUTE: rd_word       = q.sync_route;
            `PFX_OFF_STATUS:     rd_word[14:0] = filt_lvl;
            default: begin
                if (s_axi_araddr >= `PFX_OFF_DEST_BASE &&
                    s_axi_araddr <= `PFX_OFF_DEST_LAST + 8'h3) begin
                    rd_word[5:0] = q.dest_cfg[rd_idx - 6'(`PFX_OFF_DEST_BASE >> 2)];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of everything
    always_comb begin
        logic [31:0] wv;
        wv     = '0;
        next_q = q;

        // write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_q.aw_held = 1'b1;
            next_q.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_q.w_held = 1'b1;
            next_q.w_data = s_axi_wdata;
            next_q.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end

        // register write once both halves are held
        if (wr_fire) begin
            next_q.aw_held = 1'b0;
            next_q.w_held  = 1'b0;
            next_q.bvalid  = 1'b1;
            next_q.bresp   = wr_hit ? `PFX_RESP_OKAY : `PFX_RESP_SLVERR;
            unique case (q.aw_addr & 8'hfc)
                `PFX_OFF_IN_MODE: begin
                    wv             = merge_word(32'(q.in_mode), q.w_data, q.w_strb);
                    next_q.in_mode = wv[5:0];
                end
                `PFX_OFF_FILT_SEL: begin
                    wv              = merge_word(32'(q.filt_sel), q.w_data, q.w_strb);
                    next_q.filt_sel = wv[29:0];
                end
                `PFX_OFF_STATIC_OUT: begin
                    wv              = merge_word(32'(q.out_data), q.w_data, q.w_strb);
                    next_q.out_data = wv[3:0];
                end
                `PFX_OFF_OUT_MODE: begin
                    wv              = merge_word(32'(q.out_mode), q.w_data, q.w_strb);
                    next_q.out_mode = wv[3:0];
                end
                `PFX_OFF_OUT_SEL: begin
                    wv             = merge_word(32'(q.out_sel), q.w_data, q.w_strb);
                    next_q.out_sel = wv[19:0];
                end
                `PFX_OFF_SYNC_ROUTE: begin
                    next_q.sync_route = merge_word(q.sync_route, q.w_data, q.w_strb);
                end
                default: begin
                    if (wr_hit) begin
                        wv = merge_word(32'(q.dest_cfg[wr_idx - 6'(`PFX_OFF_DEST_BASE >> 2)]),
                                        q.w_data, q.w_strb);
                        next_q.dest_cfg[wr_idx - 6'(`PFX_OFF_DEST_BASE >> 2)] = wv[5:0];
                    end
                end
            endcase
        end

        // read answer one cycle after the address is taken
        if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_q.rvalid = 1'b1;
            next_q.rdata  = rd_word;
            next_q.rresp  = rd_hit ? `PFX_RESP_OKAY : `PFX_RESP_SLVERR;
        end

        // filter tick phase
        next_q.tick_cnt = (q.tick_cnt == `PFX_TICK_PERIOD - 3'h1) ? 3'h0 : q.tick_cnt + 3'h1;

        // power-up level is caught once, the cycle after reset release
        if (!q.strap_done) begin
            next_q.strap_done = 1'b1;
            next_q.out_data   = powerup_level;
        end

        // static input port shows filtered levels of static-mode pins
        next_q.static_in = filt_lvl[5:0] & q.in_mode;

        // output pins: timing export or static output bit
        for (int o = 0; o < `PFX_N_OUT; o++) begin
            if (q.out_mode[o] && q.out_sel[o*5 +: 5] < 5'(`PFX_N_SRC)) begin
                next_q.pin_out[o] = src_vec[q.out_sel[o*5 +: 5]];
            end else if (q.out_mode[o]) begin
                next_q.pin_out[o] = 1'b0;
            end else begin
                next_q.pin_out[o] = q.out_data[o];
            end
        end

        // sync bus driven from raw pins, never the filtered copy
        for (int s = 0; s < `PFX_N_SYNC; s++) begin
            next_q.sync_out[s] = 1'b0;
            if (q.sync_route[s*4 + `PFX_SR_EN] && q.sync_route[s*4 +: 3] < 3'(`PFX_N_IN)) begin
                next_q.sync_out[s] = programmable_function_pin_in[q.sync_route[s*4 +: 3]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // all state; filters reset disabled and output pins reset low
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign s_axi_bvalid                  = q.bvalid;
    assign s_axi_bresp                   = q.bresp;
    assign s_axi_rvalid                  = q.rvalid;
    assign s_axi_rresp                   = q.rresp;
    assign s_axi_rdata                   = q.rdata;
    assign programmable_function_pin_out = q.pin_out;
    assign static_input_port             = q.static_in;
    assign sync_bus_line_out             = q.sync_out;
    assign sync_bus_line_filtered        = filt_lvl[13:6];
    assign star_trigger_filtered         = filt_lvl[14];

    ////////////////////////////////////////////////////////////////////////
    chk_static_in_follow: assert property (@(posedge mclk) disable iff (!reset_n)
        static_input_port == $past(filt_lvl[5:0] & q.in_mode))
        else $error("static input port does not follow static-mode pins");
    chk_out_static_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        (!q.out_mode[0] && q.strap_done) |=> programmable_function_pin_out[0] == $past(q.out_data[0]))
        else $error("static output bit not driven on pin");
    chk_out_timing_src: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.out_mode[1] && q.out_sel[9:5] == 5'h08) |=> programmable_function_pin_out[1] == $past(star_trigger_in))
        else $error("star trigger not exported on selected pin");
    chk_sync_raw_path: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.sync_route[3:0] == 4'h8) |=> sync_bus_line_out[0] == $past(programmable_function_pin_in[0]))
        else $error("sync bus line not fed from raw pin");
    chk_powerup_low: assert property (@(posedge mclk)
        $rose(reset_n) |-> programmable_function_pin_out == 4'h0 && q.filt_sel == '0)
        else $error("outputs or filters not at reset state after release");
    chk_tick_rate: assert property (@(posedge mclk) disable iff (!reset_n)
        !filt_tick |=> filt_tick [*4])
        else $error("filter tick spacing wrong");

    cov_write_done:  cover property (@(posedge mclk) disable iff (!reset_n) wr_fire && wr_hit);
    cov_read_slverr: cover property (@(posedge mclk) disable iff (!reset_n) rd_fire && !rd_hit);
    cov_filter_pass: cover property (@(posedge mclk) disable iff (!reset_n)
        q.filt_sel[1:0] == `PFX_FILT_FAST && $rose(filt_lvl[0]));

endmodule : pfx_top
